// File: txp_device.sv
// Transmit command parser: strips command words, offsets and filler, forwards payload bytes
//
// Summary of operation
// - Read byte count from first command word.
// - Discard filler words derived from count, alignment.
// - Flag error when summed counts mismatch length.
// - Copy packet tag into transmit status word.
// - Second word bit 13 suppresses checksum append.
// - Second word bit 12 suppresses short-frame padding.
// - Padding suppressed still forces checksum append.
// - Host gives payload total in length field.
// - Host zeroes reserved bits of second word.
// - Data starts after the leading command words.
// - Low offset bits select first byte lane.
// - Upper offset bits skip whole words first.
// - Unused trailing bytes are never forwarded.
// - Host pads buffer to chosen end boundary.
// - Alignment code: 4, 16, 32 bytes, reserved.
// - Second word present only on first segment.
`timescale 1ns/1ps
module txp_device (
    input wire logic clk,
    input wire logic rst_n,
    txp_if.dev port,
    output logic mtb_valid,
    input wire logic mtb_ready,
    output logic [7:0] mtb_data,
    output logic mtb_last,
    output logic mtb_add_crc,
    output logic mtb_add_pad,
    output logic stat_valid,
    output logic [31:0] stat_word
);

    // ************************************************************
    // Helper arithmetic
    // ************************************************************

    // Words a buffer occupies after its command words, filler included
    function automatic logic [11:0] buf_words(
        input logic [3:0] skip,
        input logic [1:0] lane,
        input logic [10:0] size,
        input logic [1:0] align
    );
        logic [12:0] bytes;
        logic [11:0] used;
        bytes = {2'h0, size} + {11'h000, lane};
        used = {1'b0, bytes[12:2]} + {8'h00, skip} + {11'h000, |bytes[1:0]};
        // Reserved code falls back to word alignment, the safe reading
        if (align == txp_pkg::ALIGN_16)
            buf_words = (used + 12'h003) & 12'hFFC;
        else if (align == txp_pkg::ALIGN_32)
            buf_words = (used + 12'h007) & 12'hFF8;
        else
            buf_words = used;
    endfunction : buf_words

    // ************************************************************
    // State and per-buffer registers
    // ************************************************************
    txp_pkg::txp_state_t st_r;      // Parser state
    txp_pkg::txp_state_t st_nxt;    // Next parser state
    logic [10:0] left_r;            // Payload bytes still to forward
    logic [1:0] lane_r;             // Lane of next byte in current word
    logic [3:0] skip_r;             // Whole words to drop before data
    logic [11:0] wcnt_r;            // Words taken for this buffer
    logic [11:0] wtot_r;            // Words the buffer occupies
    logic last_r;                   // Buffer closes its packet
    logic ioc_r;                    // Completion notice requested
    logic [11:0] run_r;             // Running byte sum of the packet
    logic [10:0] plen_r;            // Declared packet length
    logic [15:0] tag_r;             // Packet tag
    logic [31:0] word_r;            // Data word, shifted one byte per beat
    logic end_q_r;                  // Buffer finished in previous cycle

    // ************************************************************
    // Decode of the offered word
    // ************************************************************
    wire logic acc = port.wvalid & port.wready;                 // Word handshake
    wire logic [31:0] w = port.wdata;                           // Offered word
    wire logic [10:0] w_size = w[txp_pkg::SIZE_LSB +: 11];
    wire logic [5:0] w_ofs = w[txp_pkg::CA_OFS_LSB +: 6];       // Start offset
    wire logic [1:0] w_align = w[txp_pkg::CA_ALIGN_LSB +: 2];   // End alignment
    wire logic w_first = w[txp_pkg::CA_FIRST_BIT];              // First segment
    wire logic [11:0] w_tot = buf_words(w_ofs[5:2], w_ofs[1:0], w_size, w_align);
    wire logic in_a = (st_r == txp_pkg::TXP_CMDA);              // Expecting first word
    wire logic in_b = (st_r == txp_pkg::TXP_CMDB);              // Expecting second word
    wire logic in_w = (st_r == txp_pkg::TXP_WORD);              // Expecting data word
    wire logic in_e = (st_r == txp_pkg::TXP_EMIT);              // Forwarding bytes
    wire logic beat = in_e & mtb_ready;                         // Byte taken by MAC side
    wire logic word_out = beat & ((left_r == 11'h001) | (lane_r == 2'h3)); // Word exhausted
    wire logic last_word = ((wcnt_r + 12'h001) == wtot_r);      // Final word of buffer
    wire logic take = (wcnt_r >= {8'h00, skip_r}) & (left_r != 11'h000); // Word carries data

    // Buffer end in any of its four forms
    wire logic end_a = in_a & acc & ~w_first & (w_tot == 12'h000);
    wire logic end_b = in_b & acc & (wtot_r == 12'h000);
    wire logic end_w = in_w & acc & ~take & last_word;
    wire logic end_e = word_out & (wcnt_r == wtot_r);
    wire logic buf_end = end_a | end_b | end_w | end_e;

    // ************************************************************
    // Next-state selection
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            txp_pkg::TXP_CMDA:
            begin
                // Second word follows only when the first segment flag is set
                if (acc)
                    st_nxt = w_first ? txp_pkg::TXP_CMDB :
                        ((w_tot == 12'h000) ? txp_pkg::TXP_CMDA : txp_pkg::TXP_WORD);
            end
            txp_pkg::TXP_CMDB:
            begin
                // Data begins on the word after the second command word
                if (acc)
                    st_nxt = (wtot_r == 12'h000) ? txp_pkg::TXP_CMDA : txp_pkg::TXP_WORD;
            end
            txp_pkg::TXP_WORD:
            begin
                // Skipped and filler words are dropped, data words go out
                if (acc)
                    st_nxt = take ? txp_pkg::TXP_EMIT :
                        (last_word ? txp_pkg::TXP_CMDA : txp_pkg::TXP_WORD);
            end
            txp_pkg::TXP_EMIT:
            begin
                if (word_out)
                    st_nxt = (wcnt_r == wtot_r) ? txp_pkg::TXP_CMDA : txp_pkg::TXP_WORD;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= txp_pkg::TXP_CMDA;
        else
            st_r <= st_nxt;
    end

    // ************************************************************
    // First command word capture and byte bookkeeping
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_r <= 11'h000;
            lane_r <= 2'h0;
            skip_r <= 4'h0;
            wtot_r <= 12'h000;
            last_r <= 1'b0;
            ioc_r <= 1'b0;
            run_r <= 12'h000;
        end
        else if (in_a & acc)
        begin
            left_r <= w_size;
            lane_r <= w_ofs[1:0];
            skip_r <= w_ofs[5:2];
            wtot_r <= w_tot;
            last_r <= w[txp_pkg::CA_LAST_BIT];
            ioc_r <= w[txp_pkg::CA_IOC_BIT];
            // A first segment restarts the sum, later ones add to it
            run_r <= w_first ? {1'b0, w_size} : run_r + {1'b0, w_size};
        end
        else if (beat)
        begin
            // Counting down the payload stops trailing bytes going out
            left_r <= left_r - 11'h001;
            lane_r <= lane_r + 2'h1;
        end
    end

    // ************************************************************
    // Word counter and data word shifter
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wcnt_r <= 12'h000;
            word_r <= 32'h0000_0000;
        end
        else if (in_a & acc)
            wcnt_r <= 12'h000;
        else if (in_w & acc)
        begin
            wcnt_r <= wcnt_r + 12'h001;
            // Lane select: move the first wanted byte to the bottom
            if (take)
                word_r <= w >> {lane_r, 3'b000};
        end
        else if (beat)
            word_r <= {8'h00, word_r[31:8]};
    end

    // ************************************************************
    // Second command word capture
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            plen_r <= 11'h000;
            tag_r <= 16'h0000;
            mtb_add_crc <= 1'b1;
            mtb_add_pad <= 1'b1;
        end
        else if (in_b & acc)
        begin
            plen_r <= w[txp_pkg::SIZE_LSB +: 11];
            tag_r <= w[txp_pkg::CB_TAG_LSB +: 16];
            // Padding off forces the checksum on regardless of its own bit
            mtb_add_crc <= ~w[txp_pkg::CB_CRC_DIS_BIT] | w[txp_pkg::CB_PAD_DIS_BIT];
            mtb_add_pad <= ~w[txp_pkg::CB_PAD_DIS_BIT];
        end
    end

    // ************************************************************
    // Buffer close: status word, length check, completion notice
    // ************************************************************
    // Closing one cycle late lets the running sum settle first; the
    // next buffer's first word cannot change it before that edge.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            end_q_r <= 1'b0;
            stat_valid <= 1'b0;
            stat_word <= 32'h0000_0000;
        end
        else
        begin
            end_q_r <= buf_end;
            stat_valid <= end_q_r & last_r;
            if (end_q_r & last_r)
                stat_word <= {tag_r, 16'h0000};
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign port.wready = in_a | in_b | in_w;                    // Stalls while forwarding
    assign port.err_pulse = end_q_r & last_r & (run_r != {1'b0, plen_r});
    assign port.loaded_pulse = end_q_r & ioc_r;
    assign mtb_valid = in_e;
    assign mtb_data = word_r[7:0];
    assign mtb_last = in_e & last_r & (left_r == 11'h001);

endmodule : txp_device

// File: txp_pkg.sv
// Shared constants and types for the transmit command parser and its host controller
package txp_pkg;

    // ************************************************************
    // First command word fields
    // ************************************************************
    localparam int CA_IOC_BIT = 31;             // Completion notice request
    localparam int CA_ALIGN_LSB = 24;           // End alignment, two bits
    localparam int CA_OFS_LSB = 16;             // Start offset, six bits
    localparam int CA_FIRST_BIT = 13;           // First segment of packet
    localparam int CA_LAST_BIT = 12;            // Last segment of packet
    localparam int SIZE_LSB = 0;                // Byte count, eleven bits
    localparam logic [31:0] CA_KEEP_MASK = 32'h833F_37FF; // Defined bits of the first word

    // ************************************************************
    // Second command word fields
    // ************************************************************
    localparam int CB_TAG_LSB = 16;             // Packet tag, sixteen bits
    localparam int CB_CRC_DIS_BIT = 13;         // Suppress appended checksum
    localparam int CB_PAD_DIS_BIT = 12;         // Suppress short-frame padding
    localparam logic [31:0] CB_KEEP_MASK = 32'hFFFF_37FF; // Reserved bits forced to zero

    // ************************************************************
    // End alignment codes
    // ************************************************************
    localparam logic [1:0] ALIGN_4 = 2'h0;      // Four-byte boundary
    localparam logic [1:0] ALIGN_16 = 2'h1;     // Sixteen-byte boundary
    localparam logic [1:0] ALIGN_32 = 2'h2;     // Thirty-two-byte boundary

    // ************************************************************
    // Controller register map (word addresses) and status layout
    // ************************************************************
    localparam logic [2:0] REG_DATA = 3'h0;     // Push raw data word
    localparam logic [2:0] REG_CMDA = 3'h1;     // Push first command word
    localparam logic [2:0] REG_CMDB = 3'h2;     // Push second command word
    localparam logic [2:0] REG_STATUS = 3'h3;   // Sticky events, read only
    localparam logic [2:0] REG_CLEAR = 3'h4;    // Write one to clear, write only
    localparam logic [2:0] REG_ENABLE = 3'h5;   // Interrupt enables
    localparam int STS_ERR_BIT = 0;             // Length mismatch seen
    localparam int STS_LOADED_BIT = 1;          // Buffer completely taken
    localparam int STS_PEND_BIT = 8;            // Word still waiting for the device
    localparam logic [1:0] EVT_RESET = 2'h0;    // Status and enable after reset

    // ************************************************************
    // Parser states
    // ************************************************************
    typedef enum logic [3:0] {
        TXP_CMDA = 4'b0001,
        TXP_CMDB = 4'b0010,
        TXP_WORD = 4'b0100,
        TXP_EMIT = 4'b1000
    } txp_state_t;

endpackage : txp_pkg

// File: txp_if.sv
// Word port between the host controller and the transmit command parser
`timescale 1ns/1ps
interface txp_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic [31:0] wdata; // Command or data word from host
    logic wvalid; // Host offers a word
    logic wready; // Device takes the word this cycle
    logic err_pulse; // Packet length mismatch, one cycle
    logic loaded_pulse;     // Buffer fully taken with notice requested, one cycle

    modport dev (
        input wdata,
        input wvalid,
        output wready,
        output err_pulse,
        output loaded_pulse
    );

    modport host (
        output wdata,
        output wvalid,
        input wready,
        input err_pulse,
        input loaded_pulse
    );
endinterface : txp_if

// File: txp_host.sv
// Host controller: Avalon-MM registers that push command and data words to the parser
`timescale 1ns/1ps
module txp_host (
    input wire logic clk,
    input wire logic rst_n,
    txp_if.host port,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic pend_r; // Word waiting for the parser
    logic [31:0] pend_data_r; // The waiting word
    logic [1:0] sts_r; // Sticky events
    logic [1:0] en_r; // Interrupt enables
    logic rd_ack_r; // Read answer ready this cycle

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic push_sel = (avs_address == txp_pkg::REG_DATA) |
        (avs_address == txp_pkg::REG_CMDA) | (avs_address == txp_pkg::REG_CMDB);
    wire logic push_stall = avs_write & push_sel & pend_r;     // Slot still occupied
    wire logic push_ok = avs_write & push_sel & ~pend_r;
    wire logic clr_wr = avs_write & (avs_address == txp_pkg::REG_CLEAR);
    wire logic en_wr = avs_write & (avs_address == txp_pkg::REG_ENABLE);
    wire logic [1:0] evt_set = {port.loaded_pulse, port.err_pulse};
    wire logic [1:0] evt_clr = clr_wr ? avs_writedata[1:0] : 2'h0;

    // Command words have their reserved bits forced to zero on the way
    wire logic [31:0] push_word =
        (avs_address == txp_pkg::REG_CMDA) ? (avs_writedata & txp_pkg::CA_KEEP_MASK) :
        (avs_address == txp_pkg::REG_CMDB) ? (avs_writedata & txp_pkg::CB_KEEP_MASK) :
        avs_writedata;

    // Read value selection
    wire logic [31:0] rd_val =
        (avs_address == txp_pkg::REG_STATUS) ? {23'h000000, pend_r, 6'h00, sts_r} :
        (avs_address == txp_pkg::REG_ENABLE) ? {30'h00000000, en_r} : 32'h0000_0000;

    // ************************************************************
    // Outgoing word slot
    // ************************************************************
    // One word of holding keeps the bus data off combinational paths
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_r <= 1'b0;
            pend_data_r <= 32'h0000_0000;
        end
        else if (push_ok)
        begin
            pend_r <= 1'b1;
            pend_data_r <= push_word;
        end
        else if (port.wready)
            pend_r <= 1'b0;
    end

    // ************************************************************
    // Sticky status and enables; a new event beats a clear
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sts_r <= txp_pkg::EVT_RESET;
            en_r <= txp_pkg::EVT_RESET;
        end
        else
        begin
            sts_r <= (sts_r & ~evt_clr) | evt_set;
            if (en_wr)
                en_r <= avs_writedata[1:0];
        end
    end

    // ************************************************************
    // Read answer, one wait cycle
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ack_r <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            rd_ack_r <= avs_read & ~rd_ack_r;
            if (avs_read & ~rd_ack_r)
                avs_readdata <= rd_val;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign avs_waitrequest = push_stall | (avs_read & ~rd_ack_r);
    assign port.wvalid = pend_r;
    assign port.wdata = pend_data_r;
    assign irq = |(sts_r & en_r);

endmodule : txp_host

// File: txp_checker.sv
// Checker for the word port between the host controller and the parser
`timescale 1ns/1ps
module txp_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] wdata,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic err_pulse,
    input wire logic loaded_pulse
);
    // ****************************************
    // Word stream tracking
    // ****************************************
    logic [1:0] ph_r; // Expected word: 0 cmd A, 1 cmd B, 2 data
    logic [10:0] left_r; // Data words still owed by the host
    wire take = wvalid && wready;
    wire [1:0] al = wdata[25:24];
    // Skip words plus data words, rounded to the end boundary
    wire [10:0] raw = 11'(wdata[21:18]) + 11'((12'(wdata[17:16]) + 12'(wdata[10:0]) + 12'h003) >> 2);
    wire [10:0] words = (al == 2'h1) ? ((raw + 11'h003) & 11'h7FC)
        : (al == 2'h2) ? ((raw + 11'h007) & 11'h7F8) : raw;
    wire [1:0] ph_nxt = (ph_r == 2'h0) ? (wdata[13] ? 2'h1 : ((words != 11'h000) ? 2'h2 : 2'h0))
        : (ph_r == 2'h1) ? ((left_r != 11'h000) ? 2'h2 : 2'h0) : ((left_r == 11'h001) ? 2'h0 : 2'h2);
    wire [10:0] left_nxt = (ph_r == 2'h0) ? words : (ph_r == 2'h2) ? left_r - 11'h001 : left_r;
    // Advance only on a handshake
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            ph_r <= 2'h0;
            left_r <= 11'h000;
        end
        else if (take)
        begin
            ph_r <= ph_nxt;
            left_r <= left_nxt;
        end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take_a; take && ph_r == 2'h0; endsequence
    sequence s_take_b; take && ph_r == 2'h1; endsequence
    property p_hold; wvalid && !wready |=> wvalid && $stable(wdata); endproperty
    property p_first_ready; !$past(rst_n) |-> wready; endproperty
    property p_cmda_rsv; s_take_a |-> (wdata & ~txp_pkg::CA_KEEP_MASK) == 32'h0; endproperty
    property p_cmdb_rsv; s_take_b |-> wdata[15:14] == 2'h0 && !wdata[11]; endproperty
    property p_cmdb_ready; ph_r == 2'h1 && wvalid |-> wready; endproperty
    property p_word_wait; wvalid && !wready |-> ##[1:200] wready; endproperty
    property p_ready_fall; $fell(wready) |-> $past(take); endproperty
    property p_close; err_pulse || loaded_pulse |-> ph_r == 2'h0; endproperty
    a_hold: assert property (p_hold) else $error("held word changed");
    a_first_ready: assert property (p_first_ready) else $error("not ready after reset");
    a_cmda_rsv: assert property (p_cmda_rsv) else $error("first word spare bits set");
    a_cmdb_rsv: assert property (p_cmdb_rsv) else $error("second word spare bits set");
    a_cmdb_ready: assert property (p_cmdb_ready) else $error("second word refused");
    a_word_wait: assert property (p_word_wait) else $error("word waits too long");
    a_ready_fall: assert property (p_ready_fall) else $error("ready fell idle");
    a_close: assert property (p_close) else $error("close inside a buffer");
endmodule : txp_checker

// File: tx_buffer_command_parser_tb_top.sv
// Bench: host registers, parser and byte stream checked end to end
`timescale 1ns/1ps
module tx_buffer_command_parser_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic mtb_ready = 1'b0;
    logic [31:0] avs_readdata, stat_word;
    logic avs_waitrequest, irq, mtb_valid, mtb_last, mtb_add_crc, mtb_add_pad, stat_valid;
    logic [7:0] mtb_data;
    logic [15:0] seed = 16'h2; // Stimulus generator state
    logic [15:0] rdy_seed = 16'h2; // Own state: stalls never shift stimulus
    logic [8:0] byte_q[$]; // Expected {last, byte}
    logic [33:0] stat_q[$]; // Expected {add_crc, add_pad, status word}
    int fail_count = 0, num_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    txp_if txp_if_i (.clk(clk), .rst_n(rst_n));
    txp_host txp_host_i (.clk(clk), .rst_n(rst_n), .port(txp_if_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
    txp_device txp_device_i (.clk(clk), .rst_n(rst_n), .port(txp_if_i), .mtb_valid(mtb_valid),
        .mtb_ready(mtb_ready), .mtb_data(mtb_data), .mtb_last(mtb_last),
        .mtb_add_crc(mtb_add_crc), .mtb_add_pad(mtb_add_pad), .stat_valid(stat_valid),
        .stat_word(stat_word));
    txp_checker txp_checker_i (.clk(clk), .rst_n(rst_n), .wdata(txp_if_i.wdata),
        .wvalid(txp_if_i.wvalid), .wready(txp_if_i.wready), .err_pulse(txp_if_i.err_pulse),
        .loaded_pulse(txp_if_i.loaded_pulse));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic rnd(output logic [31:0] r);
        r[15:0] = lfsr(seed);
        seed = lfsr(r[15:0]);
        r[31:16] = seed;
    endtask : rnd
    task automatic check(input string nm, input logic [35:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // One Avalon transfer; one idle edge after it so no signal is driven twice per step
    task automatic av(input logic [2:0] a, input logic wr, input logic [31:0] d,
        output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : av
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(a, 1'b0, 32'h0, q);
        check("readdata", 36'(q), 36'(exp));
    endtask : rd_chk
    // Push one buffer, noting every byte that must reach the MAC side
    task automatic send_buf(input logic fst, input logic ls, input logic ioc, input logic [1:0] al,
        input logic [3:0] sk, input logic [1:0] ln, input logic [10:0] sz, input logic [31:0] cb);
        int tot, idx;
        logic [31:0] w;
        tot = sk + (ln + sz + 3) / 4;
        if (al == 2'h1) tot = (tot + 3) / 4 * 4;
        if (al == 2'h2) tot = (tot + 7) / 8 * 8;
        if (ls) stat_q.push_back({!cb[13] | cb[12], !cb[12], cb[31:16], 16'h0000});
        av(txp_pkg::REG_CMDA, 1'b1, {ioc, 5'h1F, al, 2'h3, sk, ln, 2'h3, fst, ls, 1'h1, sz}, w);
        if (fst) av(txp_pkg::REG_CMDB, 1'b1, cb, w);
        for (int i = 0; i < tot; i++)
        begin
            rnd(w);
            for (int b = 0; b < 4; b++)
            begin
                idx = (i - sk) * 4 + b - ln;
                if (idx >= 0 && idx < sz) byte_q.push_back({ls && idx == sz - 1, w[8 * b +: 8]});
            end
            av(txp_pkg::REG_DATA, 1'b1, w, w);
        end
    endtask : send_buf
    task automatic drain();
        while (byte_q.size() || stat_q.size()) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : drain
    // ****************************************
    // MAC side stalls, timeout and output watcher
    // ****************************************
    always @(posedge clk)
    begin
        rdy_seed <= lfsr(rdy_seed);
        mtb_ready <= rdy_seed[0] | rdy_seed[1];
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fail_count++;
            give_verdict();
        end
        if (mtb_valid === 1'b1 && mtb_ready === 1'b1)
            check("byte", 36'({mtb_last, mtb_data}), byte_q.size() ? 36'(byte_q.pop_front()) : 'x);
        if (stat_valid === 1'b1)
            check("status", 36'({mtb_add_crc, mtb_add_pad, stat_word}), stat_q.size() ? 36'(stat_q.pop_front()) : 'x);
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [31:0] cb;
        logic [31:0] q;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Every checksum and padding code, every alignment code, every lane
        for (int k = 0; k < 4; k++)
        begin
            rnd(q);
            cb = {q[31:16], 2'h3, k[1:0], 1'h1, 11'(q[5:0]) + 11'h001};
            send_buf(1'b1, 1'b1, 1'b0, k[1:0], (k[0] == k[1]) ? {1'b0, q[8:6]} : 4'h0, k[1:0],
                cb[10:0], cb);
            drain();
        end
        rd_chk(txp_pkg::REG_STATUS, 32'h0);
        // Two segments: skip of seven words, top lane, then 32-byte end filler
        send_buf(1'b1, 1'b0, 1'b0, 2'h0, 4'h7, 2'h3, 11'h005, 32'hA5A5_000B);
        send_buf(1'b0, 1'b1, 1'b1, 2'h2, 4'h0, 2'h1, 11'h006, 32'hA5A5_000B);
        drain();
        rd_chk(txp_pkg::REG_STATUS, 32'h2);
        // Length one short of the buffer sum
        send_buf(1'b1, 1'b1, 1'b0, 2'h0, 4'h1, 2'h2, 11'h00A, 32'h1234_3009);
        drain();
        rd_chk(txp_pkg::REG_STATUS, 32'h3);
        av(txp_pkg::REG_ENABLE, 1'b1, 32'h1, q);
        rd_chk(txp_pkg::REG_ENABLE, 32'h1);
        check("irq", 36'(irq), 36'h1);
        av(txp_pkg::REG_CLEAR, 1'b1, 32'h1, q);
        check("irq", 36'(irq), 36'h0);
        rd_chk(txp_pkg::REG_STATUS, 32'h2);
        av(txp_pkg::REG_CLEAR, 1'b1, 32'h2, q);
        av(txp_pkg::REG_STATUS, 1'b1, 32'hFFFF_FFFF, q);
        rd_chk(txp_pkg::REG_STATUS, 32'h0);
        rd_chk(3'h7, 32'h0);
        give_verdict();
    end
endmodule : tx_buffer_command_parser_tb_top
